/* File: rtl/dcbs_consts.svh */
`ifndef DCBS_CONSTS_SVH
`define DCBS_CONSTS_SVH

// Overview of operation
// - Any master reset cause restarts the whole boot sequence.
// - Master boot begins when the internal reset falls inactive.
// - Control and analog sides stay in reset until master releases them.
// - Device init, then master init, then release control and analog bus.
// - Control boot runs concurrently with master boot once released.
// - Control processor idles after its init until the wake interrupt.
// - After release, sample four straps; msb strap forms bit 3.
// - Mode 0 loads over parallel pins.
// - Mode 1 branches into master RAM.
// - Mode 2 loads over async serial, sync serial or two-wire unit.
// - Mode 3 loads over master CAN.
// - Mode 4 loads over master Ethernet.
// - Mode 7 branches directly to master flash.
// - Mode 9 sync serial master load; mode 10 two-wire master load.
// - Modes 5, 8, 11 to 15 fall back to boot-to-flash.
// - Mode 6 boots from OTP only on test grade, else flash.
// - Revision 0 ignores msb strap and lacks modes 8 to 15.
// - Revision A may remap the four strap inputs to other pins.
// - Flash branch without valid code faults and loops reset until debug.
// - In mode 2 sync serial and two-wire units act as slaves.

// =====================================================================
// Phase counter start values; each phase lasts one system clock cycle more
`define DCBS_DEV_INIT_CYC 8'h10
`define DCBS_MST_INIT_CYC 8'h10
`define DCBS_CTRL_INIT_CYC 8'h10
`define DCBS_FAULT_HOLD_CYC 8'h08

// =====================================================================
// Mode numbers formed from the straps
`define DCBS_MODE_PARALLEL 4'h0
`define DCBS_MODE_RAM 4'h1
`define DCBS_MODE_SERIAL 4'h2
`define DCBS_MODE_CAN 4'h3
`define DCBS_MODE_ENET 4'h4
`define DCBS_MODE_OTP 4'h6
`define DCBS_MODE_FLASH 4'h7
`define DCBS_MODE_SSI_MST 4'h9
`define DCBS_MODE_I2C_MST 4'hA

`endif

/* File: rtl/dcbs_pkg.sv */
package dcbs_pkg;

    // =================================================================
    // Master boot phases
    typedef enum logic [3:0] {
        ST_RST,
        ST_DEV_INIT,
        ST_MST_INIT,
        ST_SAMPLE,
        ST_BRANCH,
        ST_RUN,
        ST_FAULT,
        ST_HALT
    } dcbs_state_t;

    // Control side phases
    typedef enum logic [1:0] {
        C_HELD,
        C_INIT,
        C_IDLE,
        C_RUN
    } dcbs_ctrl_t;

    // Resolved master boot source
    typedef enum logic [3:0] {
        SRC_PARALLEL,
        SRC_RAM,
        SRC_SERIAL_ANY,
        SRC_CAN,
        SRC_ENET,
        SRC_OTP,
        SRC_FLASH,
        SRC_SSI_MASTER,
        SRC_I2C_MASTER
    } dcbs_src_t;

    // =================================================================
    // Reset causes of the master side, one-cycle or level requests
    typedef struct packed {
        logic por;
        logic ext;
        logic dbg;
        logic sw;
        logic wdog;
        logic nmi_wdog;
    } dcbs_cause_t;

    // Captured boot selection
    typedef struct packed {
        logic [3:0] num;
        dcbs_src_t src;
        logic serial_slave;
        logic valid;
    } dcbs_sel_t;

    // Whole state of the sequencer
    typedef struct packed {
        dcbs_state_t st;
        dcbs_ctrl_t cst;
        logic [7:0] cnt;
        logic [7:0] ccnt;
        logic rst_q;
        logic mst_rel;
        logic ctrl_rel;
        logic anlg_rel;
        logic idle;
        logic start;
        logic fault;
        dcbs_sel_t sel;
    } dcbs_regs_t;

    // Synchroniser stages
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
    } dcbs_sync_t;

endpackage

/* File: rtl/dcbs_sync.sv */
`timescale 1ns/1ps

module dcbs_sync (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Raw pins and synchronised copy
    input wire logic [7:0] pins_in,
    output logic [7:0] pins_out
);

    dcbs_pkg::dcbs_sync_t q_q;
    dcbs_pkg::dcbs_sync_t q_d;

    // =================================================================
    // Two stages; first stage feeds only the second
    always_comb begin
        q_d = q_q;
        q_d.s1 = pins_in;
        q_d.s2 = q_q.s1;
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign pins_out = q_q.s2;

endmodule

/* File: rtl/dcbs_top.sv */
`timescale 1ns/1ps
`include "dcbs_consts.svh"

module dcbs_top (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Master reset causes
    input wire dcbs_pkg::dcbs_cause_t rst_cause_in,
    // Default strap pins
    input wire logic strap_pin_a_in,
    input wire logic strap_pin_b_in,
    input wire logic strap_pin_c_in,
    input wire logic strap_pin_d_in,
    // Alternate strap pins, msb first
    input wire logic [3:0] alt_strap_in,
    // Device options
    input wire logic silicon_rev_a_in,
    input wire logic alt_pins_en_in,
    input wire logic test_grade_in,
    // Flash and debug status
    input wire logic flash_valid_in,
    input wire logic debug_session_in,
    // Wake request from master to control
    input wire logic master_to_control_wake_irq_in,
    // Subsystem resets
    output logic master_rst_out,
    output logic control_rst_out,
    output logic analog_rst_out,
    output logic analog_interface_bus_rst_out,
    // Control processor state
    output logic ctrl_idle_out,
    // Boot selection
    output dcbs_pkg::dcbs_sel_t boot_sel_out,
    // Events
    output logic boot_start_out,
    output logic hard_fault_out
);

    // =================================================================
    // Declarations
    dcbs_pkg::dcbs_regs_t q_q;
    dcbs_pkg::dcbs_regs_t q_d;
    logic [7:0] pins_sync;
    logic int_rst;
    logic boot_sel_msb;
    logic boot_sel_bit2;
    logic boot_sel_bit1;
    logic boot_sel_lsb;
    logic [3:0] mode_num;
    dcbs_pkg::dcbs_src_t mode_src;

    // =================================================================
    // Mode decoder, used only by the sequencer; the checks do not call it
    function automatic dcbs_pkg::dcbs_src_t dcbs_decode(
        input logic [3:0] num,
        input logic rev_a,
        input logic test_grade
    );
        dcbs_pkg::dcbs_src_t s;
        s = dcbs_pkg::SRC_FLASH;
        case (num)
            `DCBS_MODE_PARALLEL: begin
                s = dcbs_pkg::SRC_PARALLEL;
            end
            `DCBS_MODE_RAM: begin
                s = dcbs_pkg::SRC_RAM;
            end
            `DCBS_MODE_SERIAL: begin
                s = dcbs_pkg::SRC_SERIAL_ANY;
            end
            `DCBS_MODE_CAN: begin
                s = dcbs_pkg::SRC_CAN;
            end
            `DCBS_MODE_ENET: begin
                s = dcbs_pkg::SRC_ENET;
            end
            `DCBS_MODE_OTP: begin
                // Other grades fall back to flash
                if (test_grade) begin
                    s = dcbs_pkg::SRC_OTP;
                end
            end
            `DCBS_MODE_FLASH: begin
                s = dcbs_pkg::SRC_FLASH;
            end
            `DCBS_MODE_SSI_MST: begin
                if (rev_a) begin
                    s = dcbs_pkg::SRC_SSI_MASTER;
                end
            end
            `DCBS_MODE_I2C_MST: begin
                if (rev_a) begin
                    s = dcbs_pkg::SRC_I2C_MASTER;
                end
            end
            default: begin
                s = dcbs_pkg::SRC_FLASH;
            end
        endcase
        return s;
    endfunction

    // =================================================================
    // Straps are board pins, so they cross into the clock domain first
    dcbs_sync u_sync (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .pins_in({strap_pin_a_in, strap_pin_b_in, strap_pin_c_in,
                  strap_pin_d_in, alt_strap_in}),
        .pins_out(pins_sync)
    );

    // Pin set choice only exists on the later revision
    always_comb begin
        if (silicon_rev_a_in && alt_pins_en_in) begin
            {boot_sel_msb, boot_sel_bit2, boot_sel_bit1, boot_sel_lsb} =
                pins_sync[3:0];
        end else begin
            {boot_sel_msb, boot_sel_bit2, boot_sel_bit1, boot_sel_lsb} =
                pins_sync[7:4];
        end
    end

    // Mode number, msb ignored on the first revision
    assign mode_num = {boot_sel_msb & silicon_rev_a_in,
                       boot_sel_bit2, boot_sel_bit1, boot_sel_lsb};
    assign mode_src = dcbs_decode(mode_num, silicon_rev_a_in,
                                  test_grade_in);

    // Any cause holds the master side in reset
    assign int_rst = |rst_cause_in;

    // =================================================================
    // Next state
    always_comb begin
        q_d = q_q;
        q_d.rst_q = int_rst;
        q_d.start = 1'b0;
        q_d.fault = 1'b0;

        // Control side advances on its own once released
        case (q_q.cst)
            dcbs_pkg::C_HELD: begin
                q_d.idle = 1'b0;
            end
            dcbs_pkg::C_INIT: begin
                if (q_q.ccnt == 8'h00) begin
                    q_d.cst = dcbs_pkg::C_IDLE;
                    q_d.idle = 1'b1;
                end else begin
                    q_d.ccnt = q_q.ccnt - 8'h01;
                end
            end
            dcbs_pkg::C_IDLE: begin
                // An early wake is lost; idle only ends on a fresh one
                if (master_to_control_wake_irq_in) begin
                    q_d.cst = dcbs_pkg::C_RUN;
                    q_d.idle = 1'b0;
                end
            end
            dcbs_pkg::C_RUN: begin
                q_d.idle = 1'b0;
            end
            default: begin
                q_d.cst = dcbs_pkg::C_HELD;
            end
        endcase

        // Master phases; reset causes override everything
        if (int_rst) begin
            q_d.st = dcbs_pkg::ST_RST;
            q_d.mst_rel = 1'b0;
            q_d.ctrl_rel = 1'b0;
            q_d.anlg_rel = 1'b0;
            q_d.cst = dcbs_pkg::C_HELD;
            q_d.idle = 1'b0;
            q_d.cnt = 8'h00;
            q_d.sel = '0;
        end else begin
            case (q_q.st)
                dcbs_pkg::ST_RST: begin
                    // Start only on the falling edge of reset
                    if (q_q.rst_q) begin
                        q_d.st = dcbs_pkg::ST_DEV_INIT;
                        q_d.mst_rel = 1'b1;
                        q_d.start = 1'b1;
                        q_d.cnt = `DCBS_DEV_INIT_CYC;
                    end
                end
                dcbs_pkg::ST_DEV_INIT: begin
                    if (q_q.cnt == 8'h00) begin
                        q_d.st = dcbs_pkg::ST_MST_INIT;
                        q_d.cnt = `DCBS_MST_INIT_CYC;
                    end else begin
                        q_d.cnt = q_q.cnt - 8'h01;
                    end
                end
                dcbs_pkg::ST_MST_INIT: begin
                    if (q_q.cnt == 8'h00) begin
                        q_d.st = dcbs_pkg::ST_SAMPLE;
                        q_d.ctrl_rel = 1'b1;
                        q_d.anlg_rel = 1'b1;
                        q_d.cst = dcbs_pkg::C_INIT;
                        q_d.ccnt = `DCBS_CTRL_INIT_CYC;
                    end else begin
                        q_d.cnt = q_q.cnt - 8'h01;
                    end
                end
                dcbs_pkg::ST_SAMPLE: begin
                    // One capture per reset, held afterwards
                    q_d.sel.num = mode_num;
                    q_d.sel.src = mode_src;
                    q_d.sel.serial_slave =
                        (mode_src == dcbs_pkg::SRC_SERIAL_ANY);
                    q_d.sel.valid = 1'b1;
                    q_d.st = dcbs_pkg::ST_BRANCH;
                end
                dcbs_pkg::ST_BRANCH: begin
                    if (q_q.sel.src == dcbs_pkg::SRC_FLASH &&
                        !flash_valid_in) begin
                        q_d.fault = 1'b1;
                        q_d.mst_rel = 1'b0;
                        q_d.ctrl_rel = 1'b0;
                        q_d.anlg_rel = 1'b0;
                        q_d.cst = dcbs_pkg::C_HELD;
                        q_d.idle = 1'b0;
                        q_d.sel = '0;
                        q_d.cnt = `DCBS_FAULT_HOLD_CYC;
                        if (debug_session_in) begin
                            q_d.st = dcbs_pkg::ST_HALT;
                        end else begin
                            q_d.st = dcbs_pkg::ST_FAULT;
                        end
                    end else begin
                        q_d.st = dcbs_pkg::ST_RUN;
                    end
                end
                dcbs_pkg::ST_FAULT: begin
                    // Blank flash keeps cycling through reset
                    if (q_q.cnt == 8'h00) begin
                        q_d.st = dcbs_pkg::ST_DEV_INIT;
                        q_d.mst_rel = 1'b1;
                        q_d.start = 1'b1;
                        q_d.cnt = `DCBS_DEV_INIT_CYC;
                    end else begin
                        q_d.cnt = q_q.cnt - 8'h01;
                    end
                end
                dcbs_pkg::ST_HALT: begin
                    // Debugger owns the part; wait for its reset
                    q_d.st = dcbs_pkg::ST_HALT;
                end
                dcbs_pkg::ST_RUN: begin
                    q_d.st = dcbs_pkg::ST_RUN;
                end
                default: begin
                    q_d.st = dcbs_pkg::ST_RST;
                end
            endcase
        end
    end

    // =================================================================
    // State register; reset looks like a pending reset edge
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            q_q <= '0;
            q_q.rst_q <= 1'b1;
        end else begin
            q_q <= q_d;
        end
    end

    // Outputs straight from the state
    assign master_rst_out = ~q_q.mst_rel;
    assign control_rst_out = ~q_q.ctrl_rel;
    assign analog_rst_out = ~q_q.anlg_rel;
    assign analog_interface_bus_rst_out = ~q_q.anlg_rel;
    assign ctrl_idle_out = q_q.idle;
    assign boot_sel_out = q_q.sel;
    assign boot_start_out = q_q.start;
    assign hard_fault_out = q_q.fault;

    // =================================================================
    // Checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    cause_holds_a: assert property (
        int_rst |=> master_rst_out && control_rst_out && !boot_sel_out.valid
    ) else $error("reset cause did not hold subsystems");

    start_on_fall_a: assert property (
        int_rst ##1 !int_rst |=> boot_start_out && !master_rst_out
    ) else $error("boot did not start on reset release");

    others_held_a: assert property (
        boot_start_out |-> control_rst_out && analog_rst_out
    ) else $error("control or analog released too early");

    release_order_a: assert property (
        $fell(control_rst_out) |->
            $past(q_q.st) == dcbs_pkg::ST_MST_INIT &&
            $fell(analog_interface_bus_rst_out) && !master_rst_out
    ) else $error("release out of order");

    ctrl_runs_a: assert property (
        $fell(control_rst_out) |-> ##[1:20]
            (ctrl_idle_out || int_rst || hard_fault_out)
    ) else $error("control boot did not reach idle");

    idle_until_wake_a: assert property (
        ctrl_idle_out && !master_to_control_wake_irq_in && !int_rst &&
        q_q.st != dcbs_pkg::ST_BRANCH |=> ctrl_idle_out
    ) else $error("control left idle without wake");

    unsup_flash_a: assert property (
        boot_sel_out.valid &&
        boot_sel_out.num inside {4'h5, 4'h8, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF}
            |-> boot_sel_out.src == dcbs_pkg::SRC_FLASH
    ) else $error("unsupported mode not mapped to flash");

    rev0_msb_a: assert property (
        $rose(boot_sel_out.valid) && !$past(silicon_rev_a_in)
            |-> !boot_sel_out.num[3]
    ) else $error("msb strap used on first revision");

    slave_mode_a: assert property (
        boot_sel_out.valid |->
            boot_sel_out.serial_slave == (boot_sel_out.num == 4'h2)
    ) else $error("serial slave flag wrong");

    blank_flash_a: assert property (
        q_q.st == dcbs_pkg::ST_BRANCH && !int_rst && !flash_valid_in &&
        boot_sel_out.src == dcbs_pkg::SRC_FLASH && !debug_session_in
            |=> hard_fault_out && master_rst_out ##9 boot_start_out
    ) else $error("blank flash did not loop reset");

    sel_held_a: assert property (
        q_q.st == dcbs_pkg::ST_RUN && !int_rst |=> $stable(boot_sel_out)
    ) else $error("boot selection changed after capture");

    run_cov: cover property (
        q_q.st == dcbs_pkg::ST_BRANCH ##1 q_q.st == dcbs_pkg::ST_RUN
    );

    fault_cov: cover property (hard_fault_out ##[1:40] boot_start_out);

    wake_cov: cover property (
        ctrl_idle_out ##1 master_to_control_wake_irq_in ##1 !ctrl_idle_out
    );

endmodule

/* File: tb/dcbs_strap_board.sv */
`timescale 1ns/1ps

module dcbs_strap_board (
    // Requested strap pattern, msb first
    input wire logic [3:0] mode_in,
    input wire logic use_alt_in,
    // Default strap pins
    output logic pin_a_out,
    output logic pin_b_out,
    output logic pin_c_out,
    output logic pin_d_out,
    // Alternate strap pins, msb first
    output logic [3:0] alt_out
);
    // =================================================================
    // Board straps
    // Every pin is always driven to a level; the set that should be
    // ignored carries the inverse pattern so a wrong pick shows up
    always_comb begin
        {pin_a_out, pin_b_out, pin_c_out, pin_d_out} =
            use_alt_in ? ~mode_in : mode_in;
        alt_out = use_alt_in ? mode_in : ~mode_in;
    end
endmodule

/* File: tb/test_dual_core_boot_sequencer.sv */
`timescale 1ns/1ps

module test_dual_core_boot_sequencer;
    // =================================================================
    // Stimulus and observation
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    dcbs_pkg::dcbs_cause_t rst_cause_in = '0;
    logic [3:0] mode = 4'h0;
    logic use_alt = 1'b0;
    logic rev_a = 1'b0;
    logic alt_en = 1'b0;
    logic test_grade = 1'b0;
    logic flash_valid = 1'b1;
    logic debug_on = 1'b0;
    logic wake = 1'b0;
    logic pin_a, pin_b, pin_c, pin_d;
    logic [3:0] alt_pins;
    logic master_rst, control_rst, analog_rst, bus_rst, ctrl_idle;
    logic boot_start, hard_fault;
    dcbs_pkg::dcbs_sel_t sel;
    int n_errors = 0;
    int num_checks = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    dcbs_strap_board u_board (
        .mode_in(mode),
        .use_alt_in(use_alt),
        .pin_a_out(pin_a),
        .pin_b_out(pin_b),
        .pin_c_out(pin_c),
        .pin_d_out(pin_d),
        .alt_out(alt_pins)
    );

    dcbs_top u_dut (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .rst_cause_in(rst_cause_in),
        .strap_pin_a_in(pin_a),
        .strap_pin_b_in(pin_b),
        .strap_pin_c_in(pin_c),
        .strap_pin_d_in(pin_d),
        .alt_strap_in(alt_pins),
        .silicon_rev_a_in(rev_a),
        .alt_pins_en_in(alt_en),
        .test_grade_in(test_grade),
        .flash_valid_in(flash_valid),
        .debug_session_in(debug_on),
        .master_to_control_wake_irq_in(wake),
        .master_rst_out(master_rst),
        .control_rst_out(control_rst),
        .analog_rst_out(analog_rst),
        .analog_interface_bus_rst_out(bus_rst),
        .ctrl_idle_out(ctrl_idle),
        .boot_sel_out(sel),
        .boot_start_out(boot_start),
        .hard_fault_out(hard_fault)
    );

    // =================================================================
    // Reporting
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait for the start pulse; a hang ends the run
    task automatic wait_start();
        int k;
        for (k = 0; k < 100 && boot_start !== 1'b1; k++) begin
            @(negedge clk_sys_in);
        end
        if (boot_start !== 1'b1) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, boot_start, 1'b1);
            end_sim();
        end
    endtask

    // =================================================================
    // Expected decode
    function automatic logic [3:0] exp_num(input logic [3:0] m,
                                           input logic ra);
        return {m[3] & ra, m[2:0]};
    endfunction

    function automatic dcbs_pkg::dcbs_src_t exp_src(input logic [3:0] n,
                                                    input logic tg);
        case (n)
            4'h0: return dcbs_pkg::SRC_PARALLEL;
            4'h1: return dcbs_pkg::SRC_RAM;
            4'h2: return dcbs_pkg::SRC_SERIAL_ANY;
            4'h3: return dcbs_pkg::SRC_CAN;
            4'h4: return dcbs_pkg::SRC_ENET;
            4'h6: return tg ? dcbs_pkg::SRC_OTP : dcbs_pkg::SRC_FLASH;
            4'h9: return dcbs_pkg::SRC_SSI_MASTER;
            4'hA: return dcbs_pkg::SRC_I2C_MASTER;
            default: return dcbs_pkg::SRC_FLASH;
        endcase
    endfunction

    // =================================================================
    // One full boot, started by one reset cause
    task automatic boot(input logic [3:0] m, input logic ra, input logic ae,
                        input logic tg, input logic fv, input logic dbg,
                        input int ci);
        logic [3:0] n;
        dcbs_pkg::dcbs_src_t s;
        logic flt;
        int k;
        n = exp_num(m, ra);
        s = exp_src(n, tg);
        flt = (s == dcbs_pkg::SRC_FLASH) && !fv;
        mode = m;
        rev_a = ra;
        alt_en = ae;
        use_alt = ae & ra;
        test_grade = tg;
        flash_valid = fv;
        debug_on = dbg;
        rst_cause_in = dcbs_pkg::dcbs_cause_t'(6'h20 >> ci);
        repeat (4) @(negedge clk_sys_in);
        chk({master_rst, control_rst, boot_start}, 8'h06);
        rst_cause_in = '0;
        wait_start();
        // Master runs alone while the other sides stay held
        for (k = 0; k < 34; k++) begin
            chk({master_rst, control_rst, analog_rst, bus_rst}, 8'h07);
            @(negedge clk_sys_in);
        end
        chk({control_rst, analog_rst, bus_rst, sel.valid}, 8'h00);
        @(negedge clk_sys_in);
        chk({sel.valid, sel.serial_slave, sel.num},
            {2'b00, 1'b1, s == dcbs_pkg::SRC_SERIAL_ANY, n});
        chk(sel.src, s);
        @(negedge clk_sys_in);
        chk({hard_fault, master_rst}, {6'h00, flt, flt});
        if (flt) begin
            // Blank flash: loop back, or park while a debugger is attached
            repeat (9) @(negedge clk_sys_in);
            chk({boot_start, master_rst}, {6'h00, !dbg, dbg});
            repeat (10) @(negedge clk_sys_in);
            if (dbg) begin
                chk({boot_start, master_rst}, 8'h01);
            end
        end else begin
            // An early wake is lost; straps change after the capture
            wake = 1'b1;
            @(negedge clk_sys_in);
            wake = 1'b0;
            mode = ~m;
            repeat (13) @(negedge clk_sys_in);
            chk(ctrl_idle, 1'b0);
            @(negedge clk_sys_in);
            chk(ctrl_idle, 1'b1);
            chk(sel.num, n);
            // Idle must hold for a cycle with no wake raised
            @(negedge clk_sys_in);
            chk(ctrl_idle, 1'b1);
            wake = 1'b1;
            @(negedge clk_sys_in);
            chk(ctrl_idle, 1'b0);
            wake = 1'b0;
        end
    endtask

    // =================================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        int i;
        r = $urandom(54);
        repeat (12) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        wait_start();
        // Every mode on revision A, strap sets and grades alternating
        for (i = 0; i < 16; i++) begin
            boot(i[3:0], 1'b1, i[0], i[1], 1'b1, 1'b0, i % 6);
        end
        // Revision 0 ignores the msb and the alternate set
        for (i = 0; i < 16; i++) begin
            boot(i[3:0], 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, i % 6);
        end
        boot(4'h7, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 0);
        boot(4'hF, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3);
        boot(4'h5, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4);
        boot(4'h7, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2);
        for (i = 0; i < 24; i++) begin
            r = $urandom;
            boot(r[3:0], r[4], r[5], r[6], r[7] | r[8], r[9],
                 int'(r[12:10]) % 6);
        end
        end_sim();
    end
endmodule
